// file: hdl/pfclc_top.sv
`timescale 1ns/1ps
`default_nettype none
module pfclc_top #(
	parameter int PWM_PERIOD = pfclc_pkg::PWM_PERIOD_DEF,
	parameter int FAST_TICK = pfclc_pkg::FAST_TICK_CYC,
	parameter int TIMEOUT = pfclc_pkg::FL_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [11:0] ref_voltage,
	input wire pfclc_pkg::pfclc_sample_s sensed_output_voltage,
	input wire pfclc_pkg::pfclc_sample_s rectified_line_voltage,
	input wire pfclc_pkg::pfclc_sample_s line_rms_value,
	input wire pfclc_pkg::pfclc_sample_s sensed_current,
	input wire logic [11:0] line_cross_threshold,
	input wire logic soft_start,
	input wire logic line_auto_en,
	input wire logic line_high_sel,
	input wire logic leading_edge_sel,
	input wire logic [7:0] k_gain,
	input wire pfclc_pkg::pfclc_coef_s coef_low_line,
	input wire pfclc_pkg::pfclc_coef_s coef_high_line,
	input wire pfclc_pkg::pfclc_coef_s coef_volt_normal,
	input wire pfclc_pkg::pfclc_coef_s coef_volt_fast,
	input wire logic aux_enable,
	input wire logic [pfclc_pkg::PWM_W-1:0] aux_start,
	input wire logic [pfclc_pkg::PWM_W-1:0] aux_stop,
	output logic main_switch_output,
	output logic aux_switch_output,
	output logic fast_loop_active,
	output logic high_line_active,
	output logic [pfclc_pkg::PWM_W-1:0] duty_cmd
);
	localparam int W = pfclc_pkg::PWM_W;

	pfclc_pkg::pfclc_state_s s_reg;
	pfclc_pkg::pfclc_state_s s_next;
	logic signed [15:0] vea;
	logic signed [15:0] ctl_out;
	logic signed [16:0] i_err;
	logic fast_v;
	pfclc_pkg::pfclc_coef_s v_coef;
	pfclc_pkg::pfclc_coef_s i_coef;

	function automatic logic [7:0] reg_read(input pfclc_pkg::pfclc_state_s st,
		input logic [15:0] addr);
		case (addr)
			pfclc_pkg::ADDR_MIN_ON_OFF: reg_read = st.min_on_off;
			pfclc_pkg::ADDR_FAST_CFG: reg_read = st.fast_cfg;
			pfclc_pkg::ADDR_HI_THR: reg_read = st.hi_thr;
			pfclc_pkg::ADDR_LO_THR: reg_read = st.lo_thr;
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	function automatic logic [11:0] avg(input logic [31:0] sum, input logic [15:0] n,
		input logic [11:0] old);
		logic [31:0] q;
		q = (n == 16'h0000) ? 32'h0 : sum / 32'(n);
		avg = (n == 16'h0000) ? old : q[11:0];
	endfunction : avg

	//------------------------------------------------------------
	// filter selection
	//------------------------------------------------------------
	// R8: voltage filter follows the fast state, current filter the line
	assign fast_v = s_reg.fl == pfclc_pkg::FL_FAST || s_reg.fl == pfclc_pkg::FL_EXIT;
	// R5: three presets picked by state
	assign v_coef = fast_v ? coef_volt_fast : coef_volt_normal;
	assign i_coef = s_reg.high_line ? coef_high_line : coef_low_line;
	// R4: current reference against sensed current
	assign i_err = 17'(s_reg.iref) - $signed({5'h00, sensed_current.data});

	pfclc_comp_filter u_volt_filt (
		.clk(clk),
		.srst(srst),
		.update(s_reg.v_upd),
		.err(s_reg.v_err),
		.coef(v_coef),
		.k_gain(k_gain),
		.y(vea)
	);

	pfclc_comp_filter u_curr_filt (
		.clk(clk),
		.srst(srst),
		.update(sensed_current.valid),
		.err(i_err),
		.coef(i_coef),
		.k_gain(k_gain),
		.y(ctl_out)
	);

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	always_comb
	begin
		logic [11:0] dev;
		logic [11:0] band;
		logic out_band;
		logic fast_en;
		logic want_high;
		logic [14:0] vea_pos;
		logic [38:0] num;
		logic [23:0] den;
		logic [38:0] q;
		logic [26:0] dscale;
		logic [W-1:0] duty;
		logic [W-1:0] min_on;
		logic [W-1:0] max_on;
		s_next = s_reg;
		s_next.zc = 1'b0;
		s_next.tick = 1'b0;
		s_next.v_upd = 1'b0;

		// register port
		if (reg_wr)
		begin
			case (reg_addr)
				pfclc_pkg::ADDR_MIN_ON_OFF: s_next.min_on_off = reg_wdata;
				pfclc_pkg::ADDR_FAST_CFG: s_next.fast_cfg = reg_wdata;
				pfclc_pkg::ADDR_HI_THR: s_next.hi_thr = reg_wdata;
				pfclc_pkg::ADDR_LO_THR: s_next.lo_thr = reg_wdata;
				default: s_next.rd_data = s_reg.rd_data;
			endcase
		end
		s_next.rd_data = reg_read(s_reg, reg_addr);

		// line period and zero crossing
		if (s_reg.period_cnt != 24'hffffff)
			s_next.period_cnt = s_reg.period_cnt + 24'h1;
		if (s_reg.zc_cnt != 24'h0)
		begin
			s_next.zc_cnt = s_reg.zc_cnt - 24'h1;
			s_next.zc = s_reg.zc_cnt == 24'h1;
		end
		if (rectified_line_voltage.valid)
		begin
			s_next.vac_last = rectified_line_voltage.data;
			// R21: crossing lies halfway to the next falling threshold crossing
			if (s_reg.vac_last >= line_cross_threshold &&
				rectified_line_voltage.data < line_cross_threshold)
			begin
				s_next.period_cnt = 24'h0;
				s_next.zc_cnt = {1'b0, s_reg.period_cnt[23:1]};
			end
		end
		if (line_rms_value.valid)
			s_next.rms = line_rms_value.data;

		// fast decimation tick
		s_next.tick_cnt = s_reg.tick_cnt + 17'h1;
		if (s_reg.tick_cnt == 17'(FAST_TICK - 1))
		begin
			s_next.tick_cnt = 17'h0;
			s_next.tick = 1'b1;
		end

		// feedback averaging
		if (sensed_output_voltage.valid)
		begin
			s_next.half_sum = s_reg.half_sum + 32'(sensed_output_voltage.data);
			s_next.half_n = s_reg.half_n + 16'h1;
			s_next.fast_sum = s_reg.fast_sum + 32'(sensed_output_voltage.data);
			s_next.fast_n = s_reg.fast_n + 16'h1;
		end
		// R22: average over one half line between crossings
		if (s_reg.zc)
		begin
			s_next.half_avg = avg(s_reg.half_sum, s_reg.half_n, s_reg.half_avg);
			s_next.half_sum = 32'h0;
			s_next.half_n = 16'h0;
		end
		// R14: average and decimate at the fast rate
		if (s_reg.tick)
		begin
			s_next.fast_avg = avg(s_reg.fast_sum, s_reg.fast_n, s_reg.fast_avg);
			s_next.fast_sum = 32'h0;
			s_next.fast_n = 16'h0;
		end

		// voltage filter feed
		// R13: normal loop once per half line, the ripple period
		if (!fast_v && s_reg.zc)
		begin
			s_next.v_upd = 1'b1;
			// R1: reference minus feedback
			s_next.v_err = 17'($signed({1'b0, ref_voltage}) - $signed({1'b0, s_next.half_avg}));
		end
		// R14: fast filter runs at the decimated rate
		if (fast_v && s_reg.tick)
		begin
			s_next.v_upd = 1'b1;
			s_next.v_err = 17'($signed({1'b0, ref_voltage}) - $signed({1'b0, s_next.fast_avg}));
		end

		// band check against decimated feedback
		dev = (ref_voltage > s_reg.fast_avg) ? ref_voltage - s_reg.fast_avg
			: s_reg.fast_avg - ref_voltage;
		// R9: band is reference over 64, 32, 16 or 8
		band = ref_voltage >> (pfclc_pkg::BAND_SHIFT_BASE -
			int'(s_reg.fast_cfg[pfclc_pkg::FAST_BAND_LSB +: 2]));
		out_band = dev > band;
		// R15: disabled means no entry
		// R16: soft start uses fast settings regardless
		fast_en = s_reg.fast_cfg[pfclc_pkg::FAST_EN_BIT] | soft_start;

		// fast loop state machine
		case (s_reg.fl)
			pfclc_pkg::FL_NORMAL:
			begin
				// R9: leave band, arm entry
				if (fast_en && out_band)
					s_next.fl = pfclc_pkg::FL_ENTER;
			end
			pfclc_pkg::FL_ENTER:
			begin
				if (!fast_en || !out_band)
					s_next.fl = pfclc_pkg::FL_NORMAL;
				// R10: swap only at a crossing
				else if (s_reg.zc)
				begin
					s_next.fl = pfclc_pkg::FL_FAST;
					s_next.fl_timer = 26'h0;
				end
			end
			pfclc_pkg::FL_FAST:
			begin
				s_next.fl_timer = s_reg.fl_timer + 26'h1;
				if (!out_band)
				begin
					s_next.fl = pfclc_pkg::FL_EXIT;
					s_next.exit_dly = 3'h0;
				end
			end
			pfclc_pkg::FL_EXIT:
			begin
				s_next.fl_timer = s_reg.fl_timer + 26'h1;
				if (out_band)
					s_next.fl = pfclc_pkg::FL_FAST;
				// R11: programmed half cycles, then next crossing
				else if (s_reg.zc)
				begin
					if (s_reg.exit_dly == s_reg.fast_cfg[pfclc_pkg::FAST_DLY_LSB +: 3])
						s_next.fl = pfclc_pkg::FL_NORMAL;
					else
						s_next.exit_dly = s_reg.exit_dly + 3'h1;
				end
			end
			default: s_next.fl = pfclc_pkg::FL_NORMAL;
		endcase
		// R12: forced return after the timeout, even out of band
		if (fast_v && s_reg.fl_timer == 26'(TIMEOUT - 1))
			s_next.fl = pfclc_pkg::FL_NORMAL;

		// line filter selection
		want_high = s_reg.high_line;
		if (s_reg.rms >= {s_reg.hi_thr, 4'h0})
			want_high = 1'b1;
		else if (s_reg.rms <= {s_reg.lo_thr, 4'h0})
			want_high = 1'b0;
		if (!line_auto_en)
		begin
			s_next.high_line = line_high_sel;
			s_next.line_cnt = 4'h0;
		end
		// R7: checked each half line, held off four full line cycles
		else if (s_reg.zc)
		begin
			if (want_high == s_reg.high_line)
				s_next.line_cnt = 4'h0;
			// R6: switch once the threshold crossing persists
			else if (s_reg.line_cnt == 4'(pfclc_pkg::LINE_WAIT_HALF - 1))
			begin
				s_next.high_line = want_high;
				s_next.line_cnt = 4'h0;
			end
			else
				s_next.line_cnt = s_reg.line_cnt + 4'h1;
		end

		// R2: current reference from multiplier and rms squared
		vea_pos = vea[15] ? 15'h0 : vea[14:0];
		num = {39'(vea_pos) * 39'(rectified_line_voltage.data)} << 12;
		den = 24'(s_reg.rms) * 24'(s_reg.rms);
		q = (den == 24'h0) ? 39'h0 : num / 39'(den);
		s_next.iref = (q > 39'h7fff) ? 16'sh7fff : $signed(q[15:0]);

		// modulator
		dscale = ctl_out[15] ? 27'h0 : 27'(ctl_out[14:0]) * 27'(PWM_PERIOD);
		duty = W'(dscale >> 15);
		// R19: minimum on time in 80 ns steps
		min_on = W'(pfclc_pkg::MIN_STEP_CYC) *
			W'(s_reg.min_on_off[pfclc_pkg::MIN_ON_LSB +: 4]);
		// R18: minimum off time, 40 ns base plus 80 ns steps
		max_on = W'(PWM_PERIOD - pfclc_pkg::MIN_OFF_BASE_CYC) - W'(pfclc_pkg::MIN_STEP_CYC) *
			W'(s_reg.min_on_off[pfclc_pkg::MIN_OFF_LSB +: 4]);
		// R23: short pulses dropped, long ones cut
		if (duty < min_on)
			duty = '0;
		if (duty > max_on)
			duty = max_on;
		s_next.pwm_cnt = (s_reg.pwm_cnt == W'(PWM_PERIOD - 1)) ? '0 : s_reg.pwm_cnt + 1'b1;
		// duty changes only at a cycle start, so no runt pulses
		if (s_reg.pwm_cnt == W'(PWM_PERIOD - 1))
			s_next.duty_act = duty;
		// R17: edge type by configuration
		if (leading_edge_sel)
			s_next.main_out = s_next.pwm_cnt >= W'(PWM_PERIOD) - s_next.duty_act;
		else
			s_next.main_out = s_next.pwm_cnt < s_next.duty_act;
		// R20: aux window has its own timing
		s_next.aux_out = aux_enable && s_next.pwm_cnt >= aux_start &&
			s_next.pwm_cnt < aux_stop;
	end

	//------------------------------------------------------------
	// state register
	//------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_reg <= '0;
			s_reg.min_on_off <= pfclc_pkg::RST_MIN_ON_OFF;
			s_reg.fast_cfg <= pfclc_pkg::RST_FAST_CFG;
			s_reg.hi_thr <= pfclc_pkg::RST_HI_THR;
			s_reg.lo_thr <= pfclc_pkg::RST_LO_THR;
			s_reg.fl <= pfclc_pkg::FL_NORMAL;
		end
		else
			s_reg <= s_next;
	end

	assign reg_rdata = s_reg.rd_data;
	assign main_switch_output = s_reg.main_out;
	assign aux_switch_output = s_reg.aux_out;
	assign fast_loop_active = fast_v;
	assign high_line_active = s_reg.high_line;
	assign duty_cmd = s_reg.duty_act;
endmodule : pfclc_top
`default_nettype wire

// file: hdl/pfclc_pkg.sv
//------------------------------------------------------------
// Contract
// R1: voltage filter error is reference minus sensed output voltage.
// R2: current reference is voltage filter output times line over rms squared.
// R3: each filter is k*b*(z - a/256)/(z - 1), a and b programmable.
// R4: current filter output, from reference minus sensed current, is duty command.
// R5: three presets: low-line current, high-line current, fast voltage filter.
// R6: auto switch line filters when rms crosses high or low threshold.
// R7: rms checked each half line; after four line cycles switch at zero crossing.
// R8: soft start pairs line current filter with normal or fast voltage filter.
// R9: fast loop entered when feedback leaves band of 1.5, 3, 6 or 12 percent.
// R10: regular to fast voltage filter swap only at a zero crossing.
// R11: back in band, wait 0 to 7 half cycles, revert at next crossing.
// R12: fast loop forced back to normal after a 630 ms timeout.
// R13: normal loop samples output once per ripple period, twice line frequency.
// R14: fast loop averages output to 1.5 kHz and runs fast filter there.
// R15: software enable for fast loop; disabled means no entry.
// R16: fast loop settings used during soft start even when disabled.
// R17: leading or trailing edge modulation chosen by configuration.
// R18: minimum off time 40 ns plus 80 ns steps, low nibble.
// R19: minimum on time 0 to 1200 ns in 80 ns steps, high nibble.
// R20: auxiliary switching output with timing independent of main output.
// R21: zero crossing is midpoint between two consecutive falling threshold crossings.
// R22: feedback averaged over each half line before normal voltage filter.
// R23: duty clamped to min on/off times; filter accumulators saturate. Duty below min on is set to zero, not raised to it.
//------------------------------------------------------------
package pfclc_pkg;
	// register map
	localparam logic [15:0] ADDR_MIN_ON_OFF = 16'hfe15;
	localparam logic [15:0] ADDR_FAST_CFG = 16'hfe24;
	localparam logic [15:0] ADDR_HI_THR = 16'hfe35;
	localparam logic [15:0] ADDR_LO_THR = 16'hfe36;
	localparam logic [7:0] RST_MIN_ON_OFF = 8'h00;
	localparam logic [7:0] RST_FAST_CFG = 8'h00;
	localparam logic [7:0] RST_HI_THR = 8'hff;
	localparam logic [7:0] RST_LO_THR = 8'h00;
	// fields
	localparam int MIN_OFF_LSB = 0;
	localparam int MIN_ON_LSB = 4;
	localparam int FAST_EN_BIT = 7;
	localparam int FAST_DLY_LSB = 4;
	localparam int FAST_BAND_LSB = 0;
	localparam int BAND_SHIFT_BASE = 6;
	localparam int THR_SHIFT = 4;
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MIN_OFF_BASE_NS = 40;
	localparam int MIN_STEP_NS = 80;
	localparam int MIN_OFF_BASE_CYC = (MIN_OFF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_STEP_CYC = (MIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAST_RATE_HZ = 1500;
	localparam int FAST_TICK_CYC = CLK_HZ / FAST_RATE_HZ;
	localparam int FL_TIMEOUT_MS = 630;
	localparam int FL_TIMEOUT_CYC = FL_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int LINE_WAIT_HALF = 8;
	localparam int PWM_PERIOD_DEF = 1000;
	localparam int PWM_W = 12;
	localparam int FILT_SHIFT = 12;
	// types
	typedef struct packed {
		logic valid;
		logic [11:0] data;
	} pfclc_sample_s;
	typedef struct packed {
		logic [7:0] zero;
		logic [7:0] gain;
	} pfclc_coef_s;
	typedef enum logic [1:0] {
		FL_NORMAL = 2'b00,
		FL_ENTER = 2'b01,
		FL_FAST = 2'b11,
		FL_EXIT = 2'b10
	} pfclc_fast_e;
	typedef struct packed {
		logic signed [15:0] y;
		logic signed [16:0] e_prev;
	} pfclc_filt_s;
	typedef struct packed {
		logic [7:0] min_on_off;
		logic [7:0] fast_cfg;
		logic [7:0] hi_thr;
		logic [7:0] lo_thr;
		logic [7:0] rd_data;
		logic [11:0] vac_last;
		logic [11:0] rms;
		logic [23:0] period_cnt;
		logic [23:0] zc_cnt;
		logic zc;
		logic [31:0] half_sum;
		logic [15:0] half_n;
		logic [31:0] fast_sum;
		logic [15:0] fast_n;
		logic [11:0] half_avg;
		logic [11:0] fast_avg;
		logic [16:0] tick_cnt;
		logic tick;
		pfclc_fast_e fl;
		logic [25:0] fl_timer;
		logic [2:0] exit_dly;
		logic high_line;
		logic [3:0] line_cnt;
		logic v_upd;
		logic signed [16:0] v_err;
		logic signed [15:0] iref;
		logic [PWM_W-1:0] pwm_cnt;
		logic [PWM_W-1:0] duty_act;
		logic main_out;
		logic aux_out;
	} pfclc_state_s;
endpackage : pfclc_pkg

// file: hdl/pfclc_comp_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pfclc_comp_filter #(
	parameter int SHIFT = pfclc_pkg::FILT_SHIFT
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic update,
	input wire logic signed [16:0] err,
	input wire pfclc_pkg::pfclc_coef_s coef,
	input wire logic [7:0] k_gain,
	output logic signed [15:0] y
);
	pfclc_pkg::pfclc_filt_s s_reg;
	pfclc_pkg::pfclc_filt_s s_next;

	//------------------------------------------------------------
	// integrator with zero
	//------------------------------------------------------------
	always_comb
	begin
		logic signed [25:0] az;
		logic signed [17:0] diff;
		logic signed [35:0] prod;
		logic signed [39:0] sum;
		az = $signed({1'b0, coef.zero}) * s_reg.e_prev;
		diff = 18'(err) - 18'(az >>> 8);
		prod = diff * $signed({1'b0, coef.gain}) * $signed({1'b0, k_gain});
		sum = 40'(s_reg.y) + 40'(prod >>> SHIFT);
		s_next = s_reg;
		if (update)
		begin
			s_next.e_prev = err;
			// R3: k*b*(z - a/256)/(z - 1)
			// R23: saturate, never wrap
			if (sum > 40'sh7fff)
				s_next.y = 16'sh7fff;
			else if (sum < -40'sh8000)
				s_next.y = -16'sh8000;
			else
				s_next.y = 16'(sum);
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign y = s_reg.y;
endmodule : pfclc_comp_filter
`default_nettype wire

// file: testbench/pfclc_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module pfclc_props #(
	parameter int PWM_PERIOD = 1000,
	parameter int TIMEOUT = 2000
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic soft_start,
	input wire logic line_auto_en,
	input wire logic line_high_sel,
	input wire logic aux_enable,
	input wire logic main_switch_output,
	input wire logic aux_switch_output,
	input wire logic fast_loop_active,
	input wire logic high_line_active,
	input wire logic [pfclc_pkg::PWM_W-1:0] duty_cmd
);
	logic [7:0] mo_reg;
	logic fen_reg;
	logic fell_reg;
	logic [11:0] hi_reg, lo_reg, age_reg;
	logic [31:0] fl_reg;
	logic mapped;
	logic mo_wr;
	assign mapped = reg_addr inside {16'hfe15, 16'hfe24, 16'hfe35, 16'hfe36};
	assign mo_wr = reg_wr && reg_addr == 16'hfe15;
	// shadows; age guards the period after a limit change
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			mo_reg <= 8'h00;
			fen_reg <= 1'b0;
			fell_reg <= 1'b0;
			age_reg <= 12'hfff;
		end
		else
		begin
			if (mo_wr)
				mo_reg <= reg_wdata;
			if (reg_wr && reg_addr == 16'hfe24)
				fen_reg <= reg_wdata[7];
			fell_reg <= fell_reg | $fell(main_switch_output);
			age_reg <= mo_wr ? 12'h000 : age_reg + 12'(age_reg != 12'hfff);
		end
		hi_reg <= main_switch_output ? hi_reg + 12'h001 : 12'h000;
		lo_reg <= main_switch_output ? 12'h000 : lo_reg + 12'(lo_reg != 12'hfff);
		fl_reg <= fast_loop_active ? fl_reg + 32'h1 : 32'h0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_reg_readback: assert property ((reg_wr && mapped) ##1 (!reg_wr && $stable(reg_addr)) |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("register readback differs");
	a_unmapped_zero: assert property (!mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_duty_min_on: assert property ((age_reg > PWM_PERIOD && duty_cmd != 0) |->
		duty_cmd >= 8 * mo_reg[7:4]) else $error("duty below minimum on");
	a_duty_max_clamp: assert property (age_reg > PWM_PERIOD |->
		duty_cmd <= PWM_PERIOD - 4 - 8 * mo_reg[3:0]) else $error("duty above maximum");
	a_pulse_width: assert property ($fell(main_switch_output) |-> hi_reg == $past(duty_cmd))
		else $error("pulse width differs from duty");
	a_min_off_time: assert property (($rose(main_switch_output) && fell_reg &&
		age_reg > PWM_PERIOD) |-> lo_reg >= 4 + 8 * mo_reg[3:0]) else $error("off time short");
	a_aux_quiet: assert property ((!aux_enable ##1 !aux_enable) |-> !aux_switch_output)
		else $error("aux output while disabled");
	a_fast_gate: assert property ($rose(fast_loop_active) |-> $past(fen_reg | soft_start))
		else $error("fast loop entered while disabled");
	a_fast_timeout: assert property (fl_reg <= TIMEOUT + 4)
		else $error("fast loop beyond timeout");
	a_manual_line: assert property ((!line_auto_en && $rose(line_high_sel)) |->
		##[1:1000] high_line_active) else $error("manual line select ignored");
endmodule : pfclc_props
bind pfclc_top pfclc_props #(.PWM_PERIOD(PWM_PERIOD), .TIMEOUT(TIMEOUT)) u_props (.clk, .srst,
	.reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .soft_start, .line_auto_en, .line_high_sel,
	.aux_enable, .main_switch_output, .aux_switch_output, .fast_loop_active, .high_line_active,
	.duty_cmd);
`default_nettype wire

// file: testbench/pfclc_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// boost stage model
// ----
module pfclc_stage_model #(
	parameter int HALF = 200
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic main_switch_output,
	input wire logic [11:0] vout_level,
	input wire logic [11:0] rms_level,
	output var pfclc_pkg::pfclc_sample_s vout_s,
	output var pfclc_pkg::pfclc_sample_s vac_s,
	output var pfclc_pkg::pfclc_sample_s rms_s,
	output var pfclc_pkg::pfclc_sample_s cur_s
);
	logic [15:0] ph_reg;
	logic [11:0] cur_reg;
	logic [11:0] vac;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ph_reg <= 16'h0000;
			cur_reg <= 12'h000;
		end
		else
		begin
			ph_reg <= (ph_reg == 16'(HALF - 1)) ? 16'h0000 : ph_reg + 16'h0001;
			// inductor ramps with the switch, floored at zero
			if (main_switch_output)
				cur_reg <= (cur_reg > 12'hf00) ? cur_reg : cur_reg + 12'h008;
			else
				cur_reg <= (cur_reg < 12'h008) ? 12'h000 : cur_reg - 12'h008;
		end
	end
	// one triangle per half line, peak near full scale
	assign vac = 12'((ph_reg < 16'(HALF / 2)) ? ph_reg * 40 : (16'(HALF) - ph_reg) * 40);
	// data shows the inverse between strobes, never a held value
	always_comb
	begin
		vac_s.valid = ph_reg[0];
		vac_s.data = vac_s.valid ? vac : ~vac;
		vout_s.valid = ph_reg[2:0] == 3'h0;
		vout_s.data = vout_s.valid ? vout_level : ~vout_level;
		rms_s.valid = ph_reg == 16'h0000;
		rms_s.data = rms_s.valid ? rms_level : ~rms_level;
		cur_s.valid = ph_reg[1:0] == 2'h1;
		cur_s.data = cur_s.valid ? cur_reg : ~cur_reg;
	end
endmodule : pfclc_stage_model
`default_nettype wire

// file: testbench/tb_pfclc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pfclc_top;
	localparam int HALF = 200;
	localparam int TMO = 2000;
	localparam logic [15:0] AD [4] = '{16'hfe15, 16'hfe24, 16'hfe35, 16'hfe36};
	localparam logic [7:0] RV [4] = '{8'h00, 8'h00, 8'hff, 8'h00};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [11:0] vout_lvl = 12'h800;
	logic [11:0] rms_lvl = 12'h400;
	logic soft_start = 1'b0;
	logic auto_en = 1'b0;
	logic hi_sel = 1'b0;
	logic lead = 1'b0;
	logic aux_en = 1'b0;
	logic [11:0] aux_st = 12'h010;
	logic [11:0] aux_sp = 12'h040;
	pfclc_pkg::pfclc_coef_s cf = 16'h0040;
	pfclc_pkg::pfclc_sample_s vout_s, vac_s, rms_s, cur_s;
	logic main_o, aux_o, fast_o, high_o;
	logic [11:0] duty;
	int fails = 0;
	int n_compared = 0;
	int n;
	always #5 clk = ~clk;
	pfclc_stage_model #(.HALF(HALF)) stage (.clk, .srst, .main_switch_output(main_o),
		.vout_level(vout_lvl), .rms_level(rms_lvl), .vout_s, .vac_s, .rms_s, .cur_s);
	pfclc_top #(.PWM_PERIOD(200), .FAST_TICK(50), .TIMEOUT(TMO)) dut (.clk, .srst, .reg_addr,
		.reg_wr, .reg_wdata, .reg_rdata, .ref_voltage(12'h800), .sensed_output_voltage(vout_s),
		.rectified_line_voltage(vac_s), .line_rms_value(rms_s), .sensed_current(cur_s),
		.line_cross_threshold(12'h200), .soft_start, .line_auto_en(auto_en),
		.line_high_sel(hi_sel), .leading_edge_sel(lead), .k_gain(8'h40), .coef_low_line(cf),
		.coef_high_line(cf), .coef_volt_normal(cf), .coef_volt_fast(cf), .aux_enable(aux_en),
		.aux_start(aux_st), .aux_stop(aux_sp), .main_switch_output(main_o),
		.aux_switch_output(aux_o), .fast_loop_active(fast_o), .high_line_active(high_o),
		.duty_cmd(duty));
	task automatic chk8(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk8
	task automatic chk1(input string nm, input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %b seen %b", nm, exp, got);
		end
	endtask : chk1
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		repeat (2) @(posedge clk);
		#1 chk8($sformatf("reg %h", a), reg_rdata, exp);
	endtask : rd
	// sampled on the falling edge, away from the launch edge
	task automatic wait_on(input bit hl, input logic want, input int lim);
		n = 0;
		while ((hl ? high_o : fast_o) !== want && n < lim)
		begin
			@(negedge clk);
			n++;
		end
	endtask : wait_on
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#1_000_000;
		fails++;
		report_and_stop();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rd(AD[i], RV[i]);
			wr(AD[i], 8'h5a ^ 8'(i));
			rd(AD[i], 8'h5a ^ 8'(i));
		end
		wr(16'hfe16, 8'ha5);
		rd(16'hfe16, 8'h00);
		rd(16'hfe15, 8'h5a);
		$display("test registers done");
		wr(16'hfe24, 8'h00);
		@(posedge clk) vout_lvl <= 12'h600;
		wait_on(0, 1'b1, 1500);
		chk1("fast disabled", fast_o, 1'b0);
		@(posedge clk) soft_start <= 1'b1;
		wait_on(0, 1'b1, 1500);
		chk1("soft start fast", fast_o, 1'b1);
		@(posedge clk)
		begin
			soft_start <= 1'b0;
			vout_lvl <= 12'h800;
		end
		wait_on(0, 1'b0, 2500);
		chk1("soft start exit", fast_o, 1'b0);
		$display("test soft start done");
		for (int b = 0; b < 4; b++)
		begin
			wr(16'hfe24, 8'h80 | 8'(b));
			@(posedge clk) vout_lvl <= 12'h800 - (12'h010 << b);
			wait_on(0, 1'b1, 800);
			chk1("inside band", fast_o, 1'b0);
			@(posedge clk) vout_lvl <= 12'h800 - (12'h040 << b);
			wait_on(0, 1'b1, 1000);
			chk1("outside band", fast_o, 1'b1);
			@(posedge clk) vout_lvl <= 12'h800;
			wait_on(0, 1'b0, 1000);
			chk1("band exit", fast_o, 1'b0);
		end
		wr(16'hfe24, 8'hb0);
		@(posedge clk) vout_lvl <= 12'h600;
		wait_on(0, 1'b1, 1000);
		@(posedge clk) vout_lvl <= 12'h800;
		wait_on(0, 1'b0, 1500);
		chk1("exit delay", n >= 3 * HALF && n <= 4 * HALF + 100, 1'b1);
		@(posedge clk) vout_lvl <= 12'h600;
		wait_on(0, 1'b1, 1000);
		wait_on(0, 1'b0, TMO + 200);
		chk1("timeout", n >= TMO - 60 && n <= TMO + 60, 1'b1);
		@(posedge clk) vout_lvl <= 12'h800;
		wait_on(0, 1'b0, 1500);
		wr(16'hfe24, 8'h00);
		$display("test fast loop done");
		wr(16'hfe35, 8'h80);
		wr(16'hfe36, 8'h20);
		@(posedge clk)
		begin
			auto_en <= 1'b1;
			rms_lvl <= 12'ha00;
		end
		wait_on(1, 1'b1, 4000);
		chk1("high line", high_o, 1'b1);
		chk1("line wait", n >= 7 * HALF, 1'b1);
		@(posedge clk) rms_lvl <= 12'h100;
		wait_on(1, 1'b0, 4000);
		chk1("low line", high_o, 1'b0);
		@(posedge clk)
		begin
			auto_en <= 1'b0;
			hi_sel <= 1'b1;
		end
		wait_on(1, 1'b1, 1000);
		chk1("manual line", high_o, 1'b1);
		$display("test line select done");
		wr(16'hfe15, 8'h21);
		@(posedge clk)
		begin
			vout_lvl <= 12'h700;
			aux_en <= 1'b1;
		end
		repeat (6000) @(posedge clk);
		n = 0;
		repeat (200) @(negedge clk) n += int'(aux_o);
		chk1("aux width", n == 48, 1'b1);
		@(posedge clk) aux_sp <= 12'h020;
		repeat (200) @(posedge clk);
		n = 0;
		repeat (200) @(negedge clk) n += int'(aux_o);
		chk1("aux narrow", n == 16, 1'b1);
		@(posedge clk) aux_en <= 1'b0;
		repeat (400) @(posedge clk);
		srst <= 1'b1;
		lead <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rd(16'hfe15, 8'h00);
		wr(16'hfe15, 8'h21);
		repeat (6000) @(posedge clk);
		$display("test modulator done");
		report_and_stop();
	end
endmodule : tb_pfclc_top
`default_nettype wire
